// ==== rtl/plc_cluster.sv ====
// cluster of programmable logic cells with shared control lines and an apb configuration port
`timescale 1ns/1ps
`default_nettype none
module plc_cluster
  import plc_pkg::*;
#(
  parameter int NCELL = PLC_NCELL
) (
  // clock, reset and freeze
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // configuration bus
  input wire plc_apb_req_s apb_req,
  output plc_apb_rsp_s apb_rsp,
  // control sources
  input wire logic [1:0] ded_clk_pin,
  input wire logic [3:0] io_in,
  input wire logic [3:0] global_in,
  input wire logic [3:0] local_ctrl,
  // cell data inputs, bit 0 is first_cell_input
  input wire logic [NCELL-1:0][3:0] cell_data,
  // chain ends
  input wire logic carry_in,
  input wire logic cascade_in,
  output logic carry_out,
  output logic cascade_out,
  // cell outputs
  output logic [NCELL-1:0] local_out,
  output logic [NCELL-1:0] global_routing_out
);

  // refuse cluster sizes the address map and status word cannot hold
  if (NCELL < 1 || NCELL > 8) begin : g_bad_ncell
    $error("plc_cluster: NCELL must be 1 to 8");
  end

  // word index of a cell configuration access
  function automatic logic [2:0] cell_index(input logic [PLC_AW-1:0] a);
    logic [PLC_AW-1:0] rel;
    rel = a - PLC_CELL_OFS;
    return rel[4:2];
  endfunction : cell_index

  // table lookup shared by every mode
  function automatic logic lut_pick(input logic [15:0] mask, input logic [3:0] idx);
    return mask[idx];
  endfunction : lut_pick

  // configuration state
  plc_ctrl_s ctrl_r;
  plc_cell_cfg_s [NCELL-1:0] cfg_r;
  logic [PLC_DW-1:0] prdata_r;
  logic [NCELL-1:0] q_r;

  // pin synchronisers: ded clocks in bits 1:0, io in bits 5:2
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic [5:0] pin_s3_r;
  logic [5:0] pin_f_r;
  logic [1:0] clk_prev_r;

  // bus decode
  wire acc = apb_req.psel & apb_req.penable;
  wire setup = apb_req.psel & ~apb_req.penable;
  wire hit_ctrl = (apb_req.paddr == PLC_CTRL_OFS);
  wire hit_stat = (apb_req.paddr == PLC_STAT_OFS);
  wire [2:0] cidx = cell_index(apb_req.paddr);
  wire hit_cell = (apb_req.paddr >= PLC_CELL_OFS) && (apb_req.paddr[1:0] == 2'h0) &&
                  ((apb_req.paddr - PLC_CELL_OFS) < PLC_AW'(4 * NCELL));
  wire mapped = hit_ctrl | hit_stat | hit_cell;
  wire bad = ~mapped | (apb_req.pwrite & hit_stat);
  wire wr_ok = acc & ce & apb_req.pwrite & ~bad;

  // shared control line selection and polarity
  wire [5:0] pin_raw = {io_in, ded_clk_pin};
  logic [3:0] ln_raw;
  logic [3:0] ln;
  logic [1:0] ctick;

  // clock lines take pins, global, io or local; clear and preset never take clock pins
  always_comb begin
    for (int j = 0; j < 2; j++) begin
      case (j == 0 ? ctrl_r.clk0_src : ctrl_r.clk1_src)
        PLC_CSRC_PIN: ln_raw[j] = pin_f_r[j];
        PLC_CSRC_GLB: ln_raw[j] = global_in[j];
        PLC_CSRC_IO: ln_raw[j] = pin_f_r[2+j];
        PLC_CSRC_LOC: ln_raw[j] = local_ctrl[j];
        default: ln_raw[j] = 1'b0;
      endcase
    end
    for (int j = 2; j < 4; j++) begin
      case (j == 2 ? ctrl_r.clr_src : ctrl_r.pre_src)
        PLC_XSRC_GLB: ln_raw[j] = global_in[j];
        PLC_XSRC_IO: ln_raw[j] = pin_f_r[2+j];
        PLC_XSRC_LOC: ln_raw[j] = local_ctrl[j];
        default: ln_raw[j] = 1'b0;
      endcase
    end
    ln = ln_raw ^ ctrl_r.inv;
    ctick = ln[1:0] & ~clk_prev_r;
  end

  // per-cell datapath and chains
  logic [NCELL:0] cy;
  logic [NCELL:0] cs;
  logic [NCELL-1:0] fn;
  logic [NCELL-1:0] gout;
  logic [NCELL-1:0] rdat;
  logic [NCELL-1:0] en;
  logic [NCELL-1:0] clr;
  logic [NCELL-1:0] pre;
  logic [3:0] idx [NCELL];

  // carry and cascade ripple from cell 0 upward
  always_comb begin
    cy[0] = carry_in;
    cs[0] = cascade_in;
    for (int i = 0; i < NCELL; i++) begin
      case (cfg_r[i].mode)
        PLC_MODE_NORMAL: begin
          idx[i] = {(cfg_r[i].reg_src == PLC_RSRC_PACK3) ? 1'b0 : cell_data[i][3],
                    cfg_r[i].cin_as_in ? cy[i] : cell_data[i][2],
                    cell_data[i][1], cell_data[i][0]};
          fn[i] = lut_pick(cfg_r[i].lut, idx[i]);
          cy[i+1] = 1'b0;
        end
        PLC_MODE_ARITH: begin
          idx[i] = {1'b0, cy[i], cell_data[i][2], cell_data[i][1]};
          fn[i] = lut_pick(cfg_r[i].lut, idx[i]);
          cy[i+1] = lut_pick(cfg_r[i].lut, {1'b1, idx[i][2:0]});
        end
        default: begin
          // counter modes: data and carry functions of carry-in, direction and feedback
          idx[i] = {1'b0, cy[i], cell_data[i][1], q_r[i]};
          fn[i] = lut_pick(cfg_r[i].lut, idx[i]);
          cy[i+1] = lut_pick(cfg_r[i].lut, {1'b1, idx[i][2:0]});
        end
      endcase
      if (cfg_r[i].casc_en) begin
        gout[i] = cfg_r[i].casc_or ? (fn[i] | cs[i]) : (fn[i] & cs[i]);
      end else begin
        gout[i] = fn[i];
      end
      cs[i+1] = gout[i];
      case (cfg_r[i].mode)
        PLC_MODE_UPDN: rdat[i] = cell_data[i][3] ? cell_data[i][2] : gout[i];
        PLC_MODE_CLRCNT: rdat[i] = cell_data[i][3] ? 1'b0 : gout[i];
        default: rdat[i] = (cfg_r[i].reg_src == PLC_RSRC_TABLE) ? gout[i] : cell_data[i][3];
      endcase
      en[i] = ctick[cfg_r[i].clk_sel] & (~cfg_r[i].ce_en | cell_data[i][0]);
      clr[i] = cfg_r[i].clr_use & ln[2];
      pre[i] = cfg_r[i].pre_use & ln[3];
    end
  end

  // outputs: local and global each pick register or table, independently
  assign carry_out = cy[NCELL];
  assign cascade_out = cs[NCELL];

  generate
    for (genvar i = 0; i < NCELL; i++) begin : g_out
      assign global_routing_out[i] = cfg_r[i].glb_from_reg ? q_r[i] : gout[i];
      // local output chooses on its own, so a packed cell can split register and table
      assign local_out[i] = cfg_r[i].loc_from_reg ? q_r[i] : gout[i];
    end
  endgenerate

  // bus answer: zero wait while running, held off while frozen
  assign apb_rsp.pready = ce;
  assign apb_rsp.pslverr = acc & bad;
  assign apb_rsp.prdata = prdata_r;

  // read data captured in the setup cycle
  logic [PLC_DW-1:0] rd_nxt;
  assign rd_nxt = hit_ctrl ? PLC_DW'(ctrl_r) :
                  hit_stat ? (PLC_DW'(ln) << PLC_STAT_LN_POS) | PLC_DW'(q_r) :
                  hit_cell ? PLC_DW'(cfg_r[cidx]) : 32'h0000_0000;

  // configuration registers and read capture
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r <= plc_ctrl_s'(PLC_CTRL_RST);
      cfg_r <= {NCELL{plc_cell_cfg_s'(PLC_CELL_RST)}};
      prdata_r <= 32'h0000_0000;
    end else if (ce) begin
      if (wr_ok && hit_ctrl) ctrl_r <= plc_ctrl_s'(apb_req.pwdata);
      if (wr_ok && hit_cell) cfg_r[cidx] <= plc_cell_cfg_s'(apb_req.pwdata);
      if (setup) prdata_r <= rd_nxt;
    end
  end

  // pin synchronisers with agreement filter, and clock line history
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
      pin_s3_r <= 6'h00;
      pin_f_r <= 6'h00;
      clk_prev_r <= 2'h0;
    end else if (ce) begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r | pin_s3_r));
      clk_prev_r <= ln[1:0];
    end
  end

  // cell registers: clear beats preset beats enabled load
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q_r <= '0;
    end else if (ce) begin
      for (int i = 0; i < NCELL; i++) begin
        if (clr[i]) q_r[i] <= 1'b0;
        else if (pre[i]) q_r[i] <= 1'b1;
        else if (en[i]) q_r[i] <= rdat[i];
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  wire c0_quiet = ce & ~clr[0] & ~pre[0];

  chk_clear_wins: assert property (ce && clr[0] |=> !q_r[0])
    else $error("cell 0 clear did not zero the register");

  chk_preset_sets: assert property (ce && !clr[0] && pre[0] |=> q_r[0])
    else $error("cell 0 preset did not set the register");

  chk_freeze_hold: assert property (!ce |=> $stable(q_r) && $stable(ctrl_r))
    else $error("state moved while clock enable low");

  chk_cell_enable: assert property (c0_quiet && cfg_r[0].ce_en && !cell_data[0][0] |=> $stable(q_r[0]))
    else $error("register loaded with first_cell_input low");

  chk_pack_direct: assert property (c0_quiet && en[0] && cfg_r[0].mode == PLC_MODE_NORMAL &&
                                    cfg_r[0].reg_src != PLC_RSRC_TABLE |=> q_r[0] == $past(cell_data[0][3]))
    else $error("packed register did not take fourth_cell_input");

  chk_normal_table: assert property (cfg_r[0].mode == PLC_MODE_NORMAL && !cfg_r[0].casc_en &&
                                     !cfg_r[0].glb_from_reg && cfg_r[0].reg_src == PLC_RSRC_TABLE &&
                                     !cfg_r[0].cin_as_in |-> global_routing_out[0] == cfg_r[0].lut[cell_data[0]])
    else $error("normal mode table output wrong");

  chk_arith_carry: assert property (cfg_r[0].mode == PLC_MODE_ARITH |->
                                    cy[1] == cfg_r[0].lut[{1'b1, carry_in, cell_data[0][2:1]}])
    else $error("arithmetic carry-out wrong");

  // arithmetic result from the lower half of the table
  chk_arith_sum: assert property (cfg_r[0].mode == PLC_MODE_ARITH && !cfg_r[0].casc_en && !cfg_r[0].glb_from_reg |->
                                  global_routing_out[0] == cfg_r[0].lut[{1'b0, carry_in, cell_data[0][2:1]}])
    else $error("arithmetic result wrong");

  // normal mode passes no carry on
  chk_normal_nocarry: assert property (cfg_r[0].mode == PLC_MODE_NORMAL |-> !cy[1])
    else $error("normal mode produced a carry");

  // local output shows the register when asked
  chk_local_reg: assert property (cfg_r[0].loc_from_reg |-> local_out[0] == q_r[0])
    else $error("local output does not show the register");

  // local output shows the table otherwise
  chk_local_table: assert property (cfg_r[0].mode == PLC_MODE_NORMAL && !cfg_r[0].casc_en &&
                                    !cfg_r[0].loc_from_reg && cfg_r[0].reg_src == PLC_RSRC_TABLE &&
                                    !cfg_r[0].cin_as_in |-> local_out[0] == cfg_r[0].lut[cell_data[0]])
    else $error("local output does not show the table");

  // and-cascade with a low chain input forces a low result
  chk_casc_and: assert property (cfg_r[0].casc_en && !cfg_r[0].casc_or && !cfg_r[0].glb_from_reg &&
                                 !cascade_in |-> !global_routing_out[0])
    else $error("and-cascade did not block");

  // or-cascade with a high chain input forces a high result
  chk_casc_or: assert property (cfg_r[0].casc_en && cfg_r[0].casc_or && !cfg_r[0].glb_from_reg &&
                                cascade_in |-> global_routing_out[0])
    else $error("or-cascade did not pass");

  // up/down counter load takes third_cell_input
  chk_updn_load: assert property (c0_quiet && en[0] && cfg_r[0].mode == PLC_MODE_UPDN && cell_data[0][3] |=>
                                  q_r[0] == $past(cell_data[0][2]))
    else $error("counter load did not take third_cell_input");

  // clearable counter clear forces zero
  chk_clrcnt_zero: assert property (c0_quiet && en[0] && cfg_r[0].mode == PLC_MODE_CLRCNT &&
                                    cell_data[0][3] |=> !q_r[0])
    else $error("counter clear did not zero the register");

  // without a clock tick the register holds
  chk_no_tick_hold: assert property (c0_quiet && !en[0] |=> $stable(q_r[0]))
    else $error("register moved without a clock tick");

  // local routing as clock line source
  chk_clk_src_loc: assert property (ctrl_r.clk0_src == PLC_CSRC_LOC |->
                                    ln[0] == (local_ctrl[0] ^ ctrl_r.inv[0]))
    else $error("clock line 0 source wrong");

  // local routing as clear line source
  chk_clr_src_loc: assert property (ctrl_r.clr_src == PLC_XSRC_LOC |->
                                    ln[2] == (local_ctrl[2] ^ ctrl_r.inv[2]))
    else $error("clear line source wrong");

  // filter follows only when the two late stages agree
  chk_filter_agree: assert property (ce && pin_s2_r[0] == pin_s3_r[0] |=> pin_f_r[0] == $past(pin_s2_r[0]))
    else $error("pin filter did not follow agreed value");

  // error only during an access
  chk_err_access: assert property (!acc |-> !apb_rsp.pslverr)
    else $error("error flagged outside an access");

  // status is read-only
  chk_stat_ro: assert property (acc && apb_req.pwrite && hit_stat |-> apb_rsp.pslverr)
    else $error("status write not refused");

  // control write lands at the access edge
  chk_ctrl_write: assert property (acc && ce && apb_req.pwrite && hit_ctrl |=>
                                   PLC_DW'(ctrl_r) == $past(apb_req.pwdata))
    else $error("control write did not land");

  chk_clk_edge: assert property (c0_quiet && !cfg_r[0].ce_en && cfg_r[0].clk_sel == 1'b0 &&
                                 $rose(ln[0]) |-> !$stable(clk_prev_r[0]) || ctick[0])
    else $error("cluster clock edge not seen");

  chk_bad_addr: assert property (acc && !mapped |-> apb_rsp.pslverr && !wr_ok)
    else $error("unmapped access not refused");

  chk_stat_view: assert property (ce && setup && !apb_req.pwrite && hit_stat |=>
                                  prdata_r[NCELL-1:0] == $past(q_r))
    else $error("status read does not show register state");

  cov_packed: cover property (c0_quiet && en[0] && cfg_r[0].reg_src == PLC_RSRC_PACK3);
  cov_arith: cover property (cfg_r[0].mode == PLC_MODE_ARITH && carry_out);
  cov_counter_load: cover property (cfg_r[0].mode == PLC_MODE_UPDN && en[0] && cell_data[0][3]);
  cov_clear: cover property (ce && clr[0]);
  cov_freeze: cover property (!ce);

endmodule : plc_cluster
`default_nettype wire

// ==== shared/plc_pkg.sv ====
// constants, field layouts and carrier types for the programmable logic cell cluster
package plc_pkg;

  localparam int PLC_NCELL = 8;
  localparam int PLC_AW = 12;
  localparam int PLC_DW = 32;

  // register byte offsets
  localparam logic [PLC_AW-1:0] PLC_CTRL_OFS = 12'h000;
  localparam logic [PLC_AW-1:0] PLC_STAT_OFS = 12'h004;
  localparam logic [PLC_AW-1:0] PLC_CELL_OFS = 12'h020;

  // reset values
  localparam logic [PLC_DW-1:0] PLC_CTRL_RST = 32'h0000_0000;
  localparam logic [PLC_DW-1:0] PLC_CELL_RST = 32'h0000_0000;

  // status field position of the shared control line levels
  localparam int PLC_STAT_LN_POS = 8;

  // cell modes
  localparam logic [1:0] PLC_MODE_NORMAL = 2'h0;
  localparam logic [1:0] PLC_MODE_ARITH = 2'h1;
  localparam logic [1:0] PLC_MODE_UPDN = 2'h2;
  localparam logic [1:0] PLC_MODE_CLRCNT = 2'h3;

  // register data sources
  localparam logic [1:0] PLC_RSRC_TABLE = 2'h0;
  localparam logic [1:0] PLC_RSRC_PACK3 = 2'h1;
  localparam logic [1:0] PLC_RSRC_PACK4 = 2'h2;

  // clock line sources
  localparam logic [1:0] PLC_CSRC_PIN = 2'h0;
  localparam logic [1:0] PLC_CSRC_GLB = 2'h1;
  localparam logic [1:0] PLC_CSRC_IO = 2'h2;
  localparam logic [1:0] PLC_CSRC_LOC = 2'h3;

  // clear and preset line sources
  localparam logic [1:0] PLC_XSRC_GLB = 2'h0;
  localparam logic [1:0] PLC_XSRC_IO = 2'h1;
  localparam logic [1:0] PLC_XSRC_LOC = 2'h2;
  localparam logic [1:0] PLC_XSRC_OFF = 2'h3;

  typedef struct packed {
    logic [2:0] rsvd;
    logic casc_or;
    logic casc_en;
    logic pre_use;
    logic clr_use;
    logic clk_sel;
    logic glb_from_reg;
    logic loc_from_reg;
    logic ce_en;
    logic [1:0] reg_src;
    logic cin_as_in;
    logic [1:0] mode;
    logic [15:0] lut;
  } plc_cell_cfg_s;

  typedef struct packed {
    logic [19:0] rsvd;
    logic [1:0] pre_src;
    logic [1:0] clr_src;
    logic [1:0] clk1_src;
    logic [1:0] clk0_src;
    logic [3:0] inv;
  } plc_ctrl_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [PLC_AW-1:0] paddr;
    logic [PLC_DW-1:0] pwdata;
  } plc_apb_req_s;

  typedef struct packed {
    logic [PLC_DW-1:0] prdata;
    logic pready;
    logic pslverr;
  } plc_apb_rsp_s;

endpackage : plc_pkg

// ==== testbench/plc_fabric_nb.sv ====
// neighbouring fabric model: drives unselected clock, io and global sources with noise
`timescale 1ns/1ps
`default_nettype none
module plc_fabric_nb (
  // clock
  input wire logic clk,
  // control sources seen by the cluster
  output logic [1:0] ded_clk_pin,
  output logic [3:0] io_in,
  output logic [3:0] global_in
);
  // sources that are not selected keep changing, so a wrong source select shows up
  initial begin
    ded_clk_pin = 2'h0;
    io_in = 4'h0;
    global_in = 4'h0;
  end
  always @(posedge clk) begin
    ded_clk_pin <= 2'($urandom);
    io_in <= 4'($urandom);
    global_in <= 4'($urandom);
  end
endmodule : plc_fabric_nb
`default_nettype wire

// ==== testbench/programmable_logic_cell_tb.sv ====
// self-checking bench for the logic cell cluster: apb config, table, arithmetic and register paths
`timescale 1ns/1ps
`default_nettype none
module programmable_logic_cell_tb;
  import plc_pkg::*;
  logic clk, rstn, ce, carry_in, cascade_in, carry_out, cascade_out, probe;
  plc_apb_req_s apb_req;
  plc_apb_rsp_s apb_rsp;
  logic [1:0] ded_clk_pin;
  logic [3:0] io_in, global_in, local_ctrl;
  logic [7:0][3:0] cell_data, cd;
  logic [7:0] local_out, global_routing_out, a, b, ex;
  logic [7:0][15:0] luts;
  logic [3:0] step;
  logic [33:0] rd_q[$];
  logic [17:0] fab_q[$];
  logic [33:0] re;
  logic [17:0] fe;
  int err_total, tests_run, cyc, seed_dummy;
  localparam logic [3:0] REG_STEPS [6] = '{4'h7, 4'h1, 4'h2, 4'h7, 4'hE, 4'h4};

  plc_cluster #(.NCELL(8)) dut (.clk(clk), .rstn(rstn), .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .ded_clk_pin(ded_clk_pin), .io_in(io_in), .global_in(global_in), .local_ctrl(local_ctrl),
    .cell_data(cell_data), .carry_in(carry_in), .cascade_in(cascade_in), .carry_out(carry_out),
    .cascade_out(cascade_out), .local_out(local_out), .global_routing_out(global_routing_out));
  plc_fabric_nb nb (.clk(clk), .ded_clk_pin(ded_clk_pin), .io_in(io_in), .global_in(global_in));

  // clock and cycle ceiling
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      wrap_up();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask : check

  task wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // one apb transfer, noting the expected response first
  task apb_xfer(input logic wr, input logic [11:0] ad, input logic [31:0] d, input logic e_err,
                input logic [31:0] e_d);
    rd_q.push_back({~wr, e_err, e_d});
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb_xfer

  // note an expected fabric observation for the next edge
  task expect_now(input logic [8:0] m, input logic [8:0] v);
    probe <= 1'b1;
    fab_q.push_back({m, v});
  endtask : expect_now

  task idle();
    @(posedge clk);
    probe <= 1'b0;
  endtask : idle

  // monitor: compares completed apb transfers and probed outputs with the oldest note
  always @(posedge clk) begin
    if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1) begin
      re = rd_q.pop_front();
      check({31'h0, apb_rsp.pslverr}, {31'h0, re[32]});
      if (re[33] && !re[32]) check(apb_rsp.prdata, re[31:0]);
    end
    if (probe) begin
      fe = fab_q.pop_front();
      check({23'h0, {carry_out, global_routing_out} & fe[17:9]}, {23'h0, fe[8:0]});
      if (fe[17:9] == 9'h0FF) check({24'h0, local_out}, {24'h0, fe[7:0]});
    end
  end

  initial begin
    clk = 1'b0; rstn = 1'b0; ce = 1'b1; apb_req = '0; carry_in = 1'b0; cascade_in = 1'b0;
    local_ctrl = 4'h0; cell_data = '0; probe = 1'b0;
    err_total = 0; tests_run = 0; cyc = 0;
    seed_dummy = $urandom(32'h809A);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // reset values and refused accesses
    apb_xfer(1'b0, PLC_CTRL_OFS, 32'h0, 1'b0, PLC_CTRL_RST);
    apb_xfer(1'b0, PLC_CELL_OFS, 32'h0, 1'b0, PLC_CELL_RST);
    apb_xfer(1'b0, 12'h100, 32'h0, 1'b1, 32'h0);
    apb_xfer(1'b1, PLC_STAT_OFS, 32'h1, 1'b1, 32'h0);
    // freeze: ready drops while clock enable is low
    @(posedge clk);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    check({31'h0, apb_rsp.pready}, 32'h0);
    ce <= 1'b1;
    // register path: both clock lines and the clear line from local routing, preset off
    apb_xfer(1'b1, PLC_CTRL_OFS, 32'h0000_0EF0, 1'b0, 32'h0);
    apb_xfer(1'b1, PLC_CELL_OFS, 32'h0AA8_0000, 1'b0, 32'h0);
    for (int s = 0; s < 6; s++) begin
      step = REG_STEPS[s];
      @(posedge clk);
      cell_data[0] <= {step[2], 2'b00, step[1]};
      local_ctrl[2] <= step[3];
      @(posedge clk);
      local_ctrl[0] <= 1'b1;
      repeat (2) @(posedge clk);
      local_ctrl[0] <= 1'b0;
      repeat (2) @(posedge clk);
      expect_now(9'h001, {8'h00, step[0]});
      idle();
      if (s == 3) apb_xfer(1'b0, PLC_STAT_OFS, 32'h0, 1'b0, 32'h0000_0001);
    end
    local_ctrl <= 4'h0;
    // normal mode: random table in every cell, random data on every cell
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 8; i++) begin
        luts[i] = 16'($urandom);
        apb_xfer(1'b1, PLC_CELL_OFS + 12'(4 * i), {16'h0000, luts[i]}, 1'b0, 32'h0);
      end
      for (int v = 0; v < 20; v++) begin
        @(posedge clk);
        cd = $urandom;
        for (int i = 0; i < 8; i++) ex[i] = luts[i][cd[i]];
        cell_data <= cd;
        carry_in <= 1'($urandom);
        expect_now(9'h0FF, {1'b0, ex});
      end
      idle();
    end
    // arithmetic mode: eight cells form a ripple adder
    for (int i = 0; i < 8; i++) begin
      apb_xfer(1'b1, PLC_CELL_OFS + 12'(4 * i), 32'h0001_E896, 1'b0, 32'h0);
    end
    for (int v = 0; v < 40; v++) begin
      @(posedge clk);
      a = 8'($urandom);
      b = (v == 0) ? ~a : 8'($urandom);
      step[0] = (v == 0) ? 1'b1 : 1'($urandom);
      for (int i = 0; i < 8; i++) cd[i] = {1'b0, b[i], a[i], 1'b0};
      cell_data <= cd;
      carry_in <= step[0];
      cascade_in <= 1'($urandom);
      expect_now(9'h1FF, 9'(a) + 9'(b) + 9'(step[0]));
      if (v == 0) begin
        idle();
      end
    end
    idle();
    repeat (2) @(posedge clk);
    wrap_up();
  end
endmodule : programmable_logic_cell_tb
`default_nettype wire
